// file: logic/cpu_bus_params.svh
// Constants for the CPU local bus control block: positions, reset values and timing counts.
`ifndef CPU_BUS_PARAMS_SVH
`define CPU_BUS_PARAMS_SVH
`define IGN_PORT_A 8'hf0
`define IGN_PORT_B 8'hf1
`define IO_PORT_W 8
`define CHAN_W 3
`define FPU_IRQ_NUM 4'hd
`define STRAP_CAPTURE_CYCLES 4'h4
`define TURBO_DIV_DEFAULT 8'h04
`define LB_CYCLES_MIN 2'h1
`endif

// file: logic/cpu_bus_pkg.sv
// Types shared by the CPU local bus control block.
package cpu_bus_pkg;
	// Cycle type pins as one group: bit2 write/read, bit1 data/control, bit0 mem/io.
	typedef struct packed {
		logic write_read_ack_bit2; // Write or read, or channel bit 2.
		logic data_control_ack_bit1; // Data or control, or channel bit 1.
		logic mem_io_ack_bit0; // Memory or I/O, or channel bit 0.
	} cyc_pins_s;
	// Decoded processor cycle kinds, coded as {write/read, data/control, mem/io}.
	typedef enum logic [2:0] {
		CYC_INTA = 3'h0, CYC_CODE = 3'h1, CYC_IORD = 3'h2, CYC_MEMRD = 3'h3,
		CYC_SPECIAL = 3'h4, CYC_HALT = 3'h5, CYC_IOWR = 3'h6, CYC_MEMWR = 3'h7
	} cyc_kind_e;
	// Processor cycle tracking states, one-hot.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001, ST_T2_FIRST = 3'b010, ST_T2_LATER = 3'b100
	} cyc_state_e;
endpackage : cpu_bus_pkg

// file: logic/strobe_divider.sv
// One-cycle enable pulse divider used to pace the non-turbo strobe.
module strobe_divider
	import cpu_bus_pkg::*;
#(
	parameter int DIV_W = 8 // Width of the divide count.
) (
	input wire logic clk_i, // System clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic [DIV_W-1:0] div_i, // Divide ratio, zero treated as one.
	output logic tick_o // One-cycle pulse every div_i cycles.
);
	initial begin
		if (DIV_W < 2) $error("strobe_divider: DIV_W must be at least 2");
	end
	logic [DIV_W-1:0] cnt_r; // Cycles left to the next pulse.
	logic [DIV_W-1:0] cnt_nxt;
	logic tick_r; // Registered pulse.
	logic tick_nxt;
	// Count down and reload, pulsing on the reload cycle.
	always_comb begin
		tick_nxt = 1'b0;
		if (cnt_r <= DIV_W'(1)) begin
			cnt_nxt = div_i;
			tick_nxt = 1'b1;
		end else begin
			cnt_nxt = cnt_r - DIV_W'(1);
		end
	end
	// Register the counter.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end
	assign tick_o = tick_r;
endmodule : strobe_divider

// file: logic/cpu_local_bus_control.sv
// CPU local bus control: hold exchange, cycle pins, strobes, cache enable and error interrupts.
`include "cpu_bus_params.svh"

// How it works
// R1: Decode cycle pins from master while unheld.
// R2: Drive DMA channel code while held.
// R3: Own address status forces data/control high.
// R4: Own address status forces mem/io high.
// R5: Write/read pin shows own access direction.
// R6: Address status low one clock, local cycles.
// R7: External strobe invalidates cache during DMA.
// R8: External strobe one cycle, protected writes.
// R9: External strobe modulated for non-turbo mode.
// R10: Float error raises interrupt line thirteen.
// R11: Raise hold when internal master needs bus.
// R12: Processor floats outputs then acknowledges hold.
// R13: Ignore error on port write with error.
// R14: Sample ignore pin at reset for timing.
// R15: Interrupt output follows valid controller request.
// R16: Cache enable off, later T2, non-cacheable.
// R17: Cache enable off first T2, local cycles.
// R18: Release cycle pins when processor owns bus.
module cpu_local_bus_control
	import cpu_bus_pkg::*;
#(
	parameter int DIV_W = 8 // Width of the non-turbo divide ratio.
) (
	input wire logic clk_i, // System clock, shared with the processor.
	input wire logic rst_i, // Synchronous power-on reset, active high.
	input wire logic master_req_i, // Internal DMA or refresh master wants the bus.
	input wire logic hold_acknowledge_i, // Processor has floated its bus.
	input wire cyc_pins_s cyc_pins_i, // Cycle type pins as seen on the wire.
	input wire logic address_status_n_i, // Address status pin level.
	input wire logic dma_ack_start_i, // Start of a DMA acknowledge cycle.
	input wire logic [`CHAN_W-1:0] dma_chan_i, // Channel being serviced.
	input wire logic own_local_start_i, // Own DMA or master cycle to a local region.
	input wire logic own_write_i, // Own local access is a write.
	input wire logic invalidate_i, // DMA or master cycle needs cache invalidate.
	input wire logic region_noncache_i, // Current processor address is non-cacheable.
	input wire logic region_local_i, // Current processor address is a local region.
	input wire logic region_wprot_i, // Current processor address is write-protected.
	input wire logic turbo_off_i, // Non-turbo mode selected.
	input wire logic [DIV_W-1:0] turbo_div_i, // Non-turbo strobe pacing ratio.
	input wire logic float_error_n_i, // Floating point error, active low.
	input wire logic io_write_i, // One-cycle pulse: internal I/O write decoded.
	input wire logic [`IO_PORT_W-1:0] io_addr_i, // Port address of that write.
	input wire logic pic_request_i, // Interrupt controller has a valid request.
	input wire logic ignore_numeric_error_n_i, // Pin level, read as strap at reset.
	output cyc_pins_s cyc_pins_o, // Cycle type pin drive values.
	output logic cyc_pins_oe_o, // High while the device drives the cycle pins.
	output logic address_status_n_o, // Address status drive value.
	output logic address_status_oe_o, // High while the device drives address status.
	output logic hold_request_o, // Hold request to the processor.
	output logic ext_address_strobe_n_o, // External address strobe, active low.
	output logic cache_enable_n_o, // Cache enable, active low.
	output logic ignore_numeric_error_n_o, // Ignore error drive value.
	output logic ignore_numeric_error_oe_o, // High while the device drives that pin.
	output logic irq_line_thirteen_o, // Internal interrupt line thirteen.
	output logic cpu_interrupt_request_o, // Interrupt request to the processor.
	output logic slot_addr_bit1_slow_o, // Strap result for slot address bit 1 timing.
	output cyc_kind_e cyc_kind_o // Decoded kind of the last processor cycle.
);
	initial begin
		if (DIV_W < 2 || DIV_W > 16) $error("cpu_local_bus_control: DIV_W out of range");
	end

	// Pin drive registers.
	cyc_pins_s pins_r, pins_nxt; // Cycle pin drive values.
	logic pins_oe_r, pins_oe_nxt; // Cycle pin enable.
	logic ads_n_r, ads_n_nxt; // Address status drive.
	logic ads_oe_r, ads_oe_nxt; // Address status enable.
	logic hold_r, hold_nxt; // Hold request.
	logic ext_address_strobe_n_n_r, ext_address_strobe_n_n_nxt; // External strobe.
	logic ken_n_r, ken_n_nxt; // Cache enable.
	logic ign_n_r, ign_n_nxt; // Ignore error drive.
	logic ign_oe_r, ign_oe_nxt; // Ignore error enable.
	logic irq_line_thirteen_r, irq_line_thirteen_nxt; // Interrupt line thirteen.
	logic cpu_interrupt_request_r, cpu_interrupt_request_nxt; // Processor interrupt request.
	logic strap_r, strap_nxt; // Captured timing strap.
	logic [3:0] por_cnt_r, por_cnt_nxt; // Cycles since reset release, held at the strap capture count.
	cyc_kind_e kind_r, kind_nxt; // Last decoded cycle kind.
	cyc_state_e st_r, st_nxt; // Processor cycle tracker.
	logic turbo_tick; // Pacing pulse for non-turbo mode.

	// The divider paces the non-turbo strobe so the slowdown ratio is software tunable.
	strobe_divider #(.DIV_W(DIV_W)) u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.div_i(turbo_div_i),
		.tick_o(turbo_tick)
	);

	// Track processor cycles: address status starts T1, then first and later T2 states.
	always_comb begin
		st_nxt = st_r;
		kind_nxt = kind_r;
		case (st_r)
			ST_IDLE: begin
				if (!hold_acknowledge_i && !address_status_n_i) begin
					st_nxt = ST_T2_FIRST;
					kind_nxt = cyc_kind_e'(cyc_pins_i); // [R1]
				end
			end
			ST_T2_FIRST: begin
				st_nxt = ST_T2_LATER;
			end
			ST_T2_LATER: begin
				// A new address status ends this cycle; held bus also ends it.
				if (hold_acknowledge_i) begin
					st_nxt = ST_IDLE;
				end else if (!address_status_n_i) begin
					st_nxt = ST_T2_FIRST;
					kind_nxt = cyc_kind_e'(cyc_pins_i); // [R1]
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// Bus ownership pins: hold request, cycle pins and address status.
	always_comb begin
		// Hold follows the internal master need; the processor answers on its own. [R11]
		hold_nxt = master_req_i; // [R11]
		pins_nxt = pins_r;
		pins_oe_nxt = hold_acknowledge_i; // [R18]
		ads_oe_nxt = hold_acknowledge_i; // [R6]
		ads_n_nxt = 1'b1;
		if (!hold_acknowledge_i) begin
			// Processor owns the bus, so stay off the shared pins. [R18]
			pins_nxt = '0;
		end else if (own_local_start_i) begin
			// Own local access: fixed data and memory, direction on write/read. [R3] [R4] [R5]
			ads_n_nxt = 1'b0; // [R6]
			pins_nxt.data_control_ack_bit1 = 1'b1; // [R3]
			pins_nxt.mem_io_ack_bit0 = 1'b1; // [R4]
			pins_nxt.write_read_ack_bit2 = own_write_i; // [R5]
		end else if (dma_ack_start_i) begin
			pins_nxt = cyc_pins_s'(dma_chan_i); // [R2]
		end
	end

	// Strobes: external address strobe and cache enable.
	always_comb begin
		ext_address_strobe_n_n_nxt = 1'b1;
		ken_n_nxt = 1'b0; // Default low, cacheable. [R16]
		if (hold_acknowledge_i && invalidate_i) begin
			ext_address_strobe_n_n_nxt = 1'b0; // [R7]
		end else if (st_nxt == ST_T2_FIRST && kind_nxt == CYC_MEMWR && region_wprot_i) begin
			ext_address_strobe_n_n_nxt = 1'b0; // One cycle in the first T2 of a protected write. [R8]
		end else if (turbo_off_i && turbo_tick) begin
			ext_address_strobe_n_n_nxt = 1'b0; // [R9]
		end
		// Memory kinds carry the mem/io pin, bit 0 of the code; the reserved halt code is not
		// a memory access and keeps caching allowed.
		if (kind_nxt[0] && kind_nxt != CYC_HALT) begin
			if (region_local_i && st_nxt != ST_IDLE) begin
				ken_n_nxt = 1'b1; // Already in the first T2. [R17]
			end else if (region_noncache_i && st_nxt == ST_T2_LATER) begin
				ken_n_nxt = 1'b1; // [R16]
			end
		end
	end

	// Numeric error, interrupts and reset strap.
	always_comb begin
		irq_line_thirteen_nxt = !float_error_n_i; // [R10]
		cpu_interrupt_request_nxt = pic_request_i; // [R15]
		ign_n_nxt = ign_n_r;
		ign_oe_nxt = ign_oe_r;
		strap_nxt = strap_r;
		por_cnt_nxt = por_cnt_r;
		if (por_cnt_r < `STRAP_CAPTURE_CYCLES) begin
			// Pin stays an input while the strap settles after reset. [R14]
			por_cnt_nxt = por_cnt_r + 4'h1;
			if (por_cnt_r == `STRAP_CAPTURE_CYCLES - 4'h1) begin
				strap_nxt = ignore_numeric_error_n_i; // [R14]
				ign_oe_nxt = 1'b1;
			end
		end else if (io_write_i && !float_error_n_i &&
				(io_addr_i == `IGN_PORT_A || io_addr_i == `IGN_PORT_B)) begin
			ign_n_nxt = 1'b0; // [R13]
		end else if (float_error_n_i) begin
			// The error went away, so the ignore request ends too.
			ign_n_nxt = 1'b1;
		end
	end

	// Register all state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins_r <= '0;
			pins_oe_r <= 1'b0;
			ads_n_r <= 1'b1;
			ads_oe_r <= 1'b0;
			hold_r <= 1'b0;
			ext_address_strobe_n_n_r <= 1'b1;
			ken_n_r <= 1'b0;
			ign_n_r <= 1'b1;
			ign_oe_r <= 1'b0;
			irq_line_thirteen_r <= 1'b0;
			cpu_interrupt_request_r <= 1'b0;
			strap_r <= 1'b0;
			por_cnt_r <= 4'h0;
			kind_r <= CYC_INTA;
			st_r <= ST_IDLE;
		end else begin
			pins_r <= pins_nxt;
			pins_oe_r <= pins_oe_nxt;
			ads_n_r <= ads_n_nxt;
			ads_oe_r <= ads_oe_nxt;
			hold_r <= hold_nxt;
			ext_address_strobe_n_n_r <= ext_address_strobe_n_n_nxt;
			ken_n_r <= ken_n_nxt;
			ign_n_r <= ign_n_nxt;
			ign_oe_r <= ign_oe_nxt;
			irq_line_thirteen_r <= irq_line_thirteen_nxt;
			cpu_interrupt_request_r <= cpu_interrupt_request_nxt;
			strap_r <= strap_nxt;
			por_cnt_r <= por_cnt_nxt;
			kind_r <= kind_nxt;
			st_r <= st_nxt;
		end
	end

	assign cyc_pins_o = pins_r;
	assign cyc_pins_oe_o = pins_oe_r;
	assign address_status_n_o = ads_n_r;
	assign address_status_oe_o = ads_oe_r;
	assign hold_request_o = hold_r;
	assign ext_address_strobe_n_o = ext_address_strobe_n_n_r;
	assign cache_enable_n_o = ken_n_r;
	assign ignore_numeric_error_n_o = ign_n_r;
	assign ignore_numeric_error_oe_o = ign_oe_r;
	assign irq_line_thirteen_o = irq_line_thirteen_r;
	assign cpu_interrupt_request_o = cpu_interrupt_request_r;
	assign slot_addr_bit1_slow_o = strap_r;
	assign cyc_kind_o = kind_r;

	// Checks next to the logic they guard.
	chk_pins_released: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		!hold_acknowledge_i |=> !cyc_pins_oe_o)
		else $error("cycle pins driven while processor owns bus");
	chk_chan_code: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		hold_acknowledge_i && dma_ack_start_i && !own_local_start_i
		|=> cyc_pins_o == cyc_pins_s'($past(dma_chan_i)))
		else $error("channel code not on cycle pins");
	chk_own_pins_high: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		!address_status_n_o && address_status_oe_o |-> cyc_pins_o.data_control_ack_bit1)
		else $error("data/control low during own address status");
	chk_own_mem_high: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		!address_status_n_o && address_status_oe_o |-> cyc_pins_o.mem_io_ack_bit0)
		else $error("mem/io low during own address status");
	chk_own_dir: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
		hold_acknowledge_i && own_local_start_i
		|=> cyc_pins_o.write_read_ack_bit2 == $past(own_write_i))
		else $error("write/read pin wrong for own access");
	chk_ads_one_clock: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		hold_acknowledge_i && own_local_start_i ##1 !own_local_start_i |=> address_status_n_o)
		else $error("address status held longer than one clock");
	chk_invalidate: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		hold_acknowledge_i && invalidate_i |=> !ext_address_strobe_n_o)
		else $error("no invalidate strobe during held cycle");
	chk_hold_follow: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		master_req_i |=> hold_request_o)
		else $error("hold request not raised");
	chk_irq_line_thirteen: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
		!float_error_n_i |=> irq_line_thirteen_o)
		else $error("float error did not raise line thirteen");
	chk_cpu_interrupt_request: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		pic_request_i |=> cpu_interrupt_request_o)
		else $error("interrupt request not passed on");
	chk_ignore_err: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
		ignore_numeric_error_oe_o && io_write_i && !float_error_n_i && io_addr_i == `IGN_PORT_A
		|=> !ignore_numeric_error_n_o)
		else $error("ignore error not asserted on port write");
	chk_strap_input: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		$past(rst_i) |-> !ignore_numeric_error_oe_o)
		else $error("ignore pin driven right after reset");
	// Cache enable is judged on the kind and region that were sampled one edge earlier.
	chk_ken_local: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
		st_r == ST_T2_FIRST && kind_r[0] && kind_r != CYC_HALT && $past(region_local_i)
		|-> cache_enable_n_o)
		else $error("cache enable active in first T2 of a local cycle");
	chk_ken_noncache: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		st_r == ST_T2_LATER && kind_r[0] && kind_r != CYC_HALT && $past(region_noncache_i)
		|-> cache_enable_n_o)
		else $error("cache enable active in later T2 of a non-cacheable cycle");
	chk_ken_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		st_r == ST_IDLE |-> !cache_enable_n_o)
		else $error("cache enable inactive outside processor cycles");
	chk_wprot_strobe: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		st_r == ST_T2_FIRST && kind_r == CYC_MEMWR && $past(region_wprot_i)
		|-> !ext_address_strobe_n_o)
		else $error("no strobe in first T2 of a protected write");
	// Past the first T2 only pacing or invalidation may pull the strobe low.
	chk_wprot_once: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		st_r == ST_T2_LATER && !$past(turbo_off_i) && !$past(hold_acknowledge_i)
		|-> ext_address_strobe_n_o)
		else $error("protected write strobe longer than one cycle");
	chk_strap_capture: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		$rose(ignore_numeric_error_oe_o)
		|-> slot_addr_bit1_slow_o == $past(ignore_numeric_error_n_i))
		else $error("strap not captured from the ignore pin");
	cov_dma_code: cover property (@(posedge clk_i) hold_acknowledge_i && dma_ack_start_i);
	cov_own_local: cover property (@(posedge clk_i) !address_status_n_o && address_status_oe_o);
	cov_wprot: cover property (@(posedge clk_i) st_r == ST_T2_FIRST && !ext_address_strobe_n_o);
	cov_ignore: cover property (@(posedge clk_i) !ignore_numeric_error_n_o);
endmodule : cpu_local_bus_control

// file: tb/cpu_model.sv
// Processor model on the local bus: hold exchange and processor cycle starts.
module cpu_model
	import cpu_bus_pkg::*;
(
	input wire logic clk_i, // Shared clock.
	input wire logic hold_request_i, // Hold request from the device.
	input wire logic slow_i, // Answer hold two cycles later.
	input wire logic go_i, // Start one processor cycle.
	input wire logic [2:0] code_i, // Kind of cycle to start.
	output logic hold_acknowledge_o, // Bus handed over.
	output cyc_pins_s pins_o, // Cycle pin drive.
	output logic ads_n_o // Address status drive.
);
	timeunit 1ns;
	timeprecision 100ps;
	int wait_n = 0; // Cycles left before floating.
	logic floated = 1'b0; // Outputs already floated.
	initial begin
		hold_acknowledge_o = 1'b0;
		pins_o = '0;
		ads_n_o = 1'b1;
	end
	// A released wire toggles, address status only while hold is still requested, so that no stale level can pass for a valid one.
	always @(posedge clk_i) begin
		if (hold_acknowledge_o) begin
			pins_o <= ~pins_o;
			ads_n_o <= hold_request_i ? ~ads_n_o : 1'b1;
		end else if (go_i) begin
			pins_o <= code_i;
			ads_n_o <= 1'b0;
		end else begin
			ads_n_o <= 1'b1;
		end
		if (!hold_request_i) begin
			hold_acknowledge_o <= 1'b0;
			floated <= 1'b0;
			wait_n <= slow_i ? 2 : 0;
		end else if (wait_n > 0) begin
			wait_n <= wait_n - 1;
		end else if (!floated) begin
			floated <= 1'b1;
		end else begin
			hold_acknowledge_o <= 1'b1;
		end
	end
endmodule : cpu_model

// file: tb/test_cpu_local_bus_control.sv
// Self-checking bench for the CPU local bus control block.
module test_cpu_local_bus_control;
	timeunit 1ns;
	timeprecision 100ps;
	import cpu_bus_pkg::*;
	logic clk_i = 0, rst_i = 1, master_req_i = 0, dma_ack_start_i = 0, own_local_start_i = 0;
	logic own_write_i = 0, invalidate_i = 0, region_noncache_i = 0, region_local_i = 0;
	logic region_wprot_i = 0, turbo_off_i = 0, float_error_n_i = 1, io_write_i = 0;
	logic pic_request_i = 0, strap = 0, slow = 0, go = 0, m;
	logic [2:0] dma_chan_i = 0, code = 0;
	logic [7:0] turbo_div_i = 8'h04, io_addr_i = 8'h00;
	logic [31:0] r; // Random bits for one step.
	cyc_pins_s cyc_pins_i, cyc_pins_o, cpu_pins;
	cyc_kind_e cyc_kind_o;
	logic hold_acknowledge_i, address_status_n_i, cpu_ads_n, ign_wire, cyc_pins_oe_o;
	logic address_status_n_o, address_status_oe_o, hold_request_o, ext_address_strobe_n_o;
	logic cache_enable_n_o, ignore_numeric_error_n_o, ignore_numeric_error_oe_o;
	logic irq_line_thirteen_o, cpu_interrupt_request_o, slot_bit1;
	int num_errors = 0, n_tests = 0, cnt;
	// Wire levels: whoever enables its driver wins, otherwise the processor or strap.
	assign cyc_pins_i = cyc_pins_oe_o ? cyc_pins_o : cpu_pins;
	assign address_status_n_i = address_status_oe_o ? address_status_n_o : cpu_ads_n;
	assign ign_wire = ignore_numeric_error_oe_o ? ignore_numeric_error_n_o : strap;
	cpu_local_bus_control dut (.clk_i, .rst_i, .master_req_i, .hold_acknowledge_i, .cyc_pins_i,
		.address_status_n_i, .dma_ack_start_i, .dma_chan_i, .own_local_start_i, .own_write_i,
		.invalidate_i, .region_noncache_i, .region_local_i, .region_wprot_i, .turbo_off_i,
		.turbo_div_i, .float_error_n_i, .io_write_i, .io_addr_i, .pic_request_i,
		.ignore_numeric_error_n_i(ign_wire), .cyc_pins_o, .cyc_pins_oe_o, .address_status_n_o,
		.address_status_oe_o, .hold_request_o, .ext_address_strobe_n_o, .cache_enable_n_o,
		.ignore_numeric_error_n_o, .ignore_numeric_error_oe_o, .irq_line_thirteen_o,
		.cpu_interrupt_request_o, .slot_addr_bit1_slow_o(slot_bit1), .cyc_kind_o);
	cpu_model cpu (.clk_i, .hold_request_i(hold_request_o), .slow_i(slow), .go_i(go),
		.code_i(code), .hold_acknowledge_o(hold_acknowledge_i), .pins_o(cpu_pins),
		.ads_n_o(cpu_ads_n));
	// Clock at 40 MHz.
	always #12.5 clk_i = ~clk_i;
	// Inputs move 2 ns after the edge, so results are read once settled.
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask : tick
	// One comparison; case inequality so an unknown never matches.
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Bounded wait for the processor to reach the given acknowledge level.
	task automatic wait_ack(input logic v);
		for (int k = 0; k < 20 && hold_acknowledge_i !== v; k++) tick(1);
		chk("ack", {7'h00, v}, {7'h00, hold_acknowledge_i});
	endtask : wait_ack
	task automatic wrap_up;
		if (num_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#(25 * 4000);
		num_errors++;
		wrap_up();
	end
	initial begin
		r = $urandom(28);
		strap = r[3];
		turbo_div_i = 8'h02 << (r % 3);
		tick(4);
		rst_i = 0;
		tick(1);
		chk("ign_oe_strap", 0, ignore_numeric_error_oe_o);
		tick(5);
		chk("ign_oe_after", 1, ignore_numeric_error_oe_o);
		chk("strap", strap, slot_bit1);
		// Every processor cycle kind, regions random on all kinds; only memory kinds react.
		for (int k = 0; k < 8; k++) begin
			r = $urandom;
			m = (k == 1) || (k == 3) || (k == 7);
			code = 3'(k);
			region_wprot_i = r[0];
			region_noncache_i = r[1];
			region_local_i = r[2];
			go = 1;
			tick(1);
			go = 0;
			tick(1);
			chk("kind", 8'(k), cyc_kind_o);
			chk("ext_address_strobe_n_t2a", !(k == 7 && r[0]), ext_address_strobe_n_o);
			chk("ken_t2a", m & region_local_i, cache_enable_n_o);
			tick(1);
			chk("ext_address_strobe_n_t2b", 1, ext_address_strobe_n_o);
			chk("ken_t2b", m & (region_local_i | region_noncache_i), cache_enable_n_o);
			tick(2);
		end
		region_wprot_i = 0;
		region_noncache_i = 0;
		region_local_i = 0;
		// Hold exchange with each channel code, processor prompt or slow at random.
		for (int c = 0; c < 8; c++) begin
			r = $urandom;
			slow = r[0];
			master_req_i = 1;
			tick(1);
			chk("hold", 1, hold_request_o);
			wait_ack(1);
			dma_chan_i = 3'(c);
			dma_ack_start_i = 1;
			tick(1);
			dma_ack_start_i = 0;
			chk("chan", 8'(c), cyc_pins_o);
			chk("pins_oe", 1, cyc_pins_oe_o);
			own_local_start_i = 1;
			own_write_i = r[1];
			tick(1);
			own_local_start_i = 0;
			chk("ads", 0, address_status_n_o);
			chk("ads_oe", 1, address_status_oe_o);
			chk("pins_own", {5'h00, r[1], 2'b11}, cyc_pins_o);
			invalidate_i = 1;
			tick(1);
			chk("ads_end", 1, address_status_n_o);
			chk("ext_address_strobe_n_inv", 0, ext_address_strobe_n_o);
			invalidate_i = 0;
			master_req_i = 0;
			tick(1);
			chk("hold_off", 0, hold_request_o);
			wait_ack(0);
			tick(1);
			chk("pins_rel", 0, cyc_pins_oe_o);
		end
		// Port writes F0, F1 and a neighbour with the error, each followed by a cycle with the error cleared and no write.
		for (int p = 0; p < 3; p++) begin
			float_error_n_i = 0;
			io_addr_i = 8'hf0 + 8'(p);
			io_write_i = 1;
			tick(1);
			chk("irq_line_thirteen", 1, irq_line_thirteen_o);
			chk("ign_on", p == 2, ignore_numeric_error_n_o);
			float_error_n_i = 1;
			io_write_i = 0;
			tick(1);
			chk("irq_line_thirteen_off", 0, irq_line_thirteen_o);
			chk("ign_off", 1, ignore_numeric_error_n_o);
		end
		pic_request_i = 1;
		tick(1);
		chk("cpu_interrupt_request", 1, cpu_interrupt_request_o);
		pic_request_i = 0;
		tick(1);
		chk("cpu_interrupt_request_off", 0, cpu_interrupt_request_o);
		// Second reset in mid-run: the strap flips and a port write in the window is refused.
		rst_i = 1;
		strap = ~strap;
		tick(4);
		rst_i = 0;
		float_error_n_i = 0;
		io_addr_i = 8'hf0;
		io_write_i = 1;
		tick(1);
		io_write_i = 0;
		float_error_n_i = 1;
		chk("ign_refused", 1, ignore_numeric_error_n_o);
		chk("ign_oe_reset", 0, ignore_numeric_error_oe_o);
		tick(5);
		chk("ign_oe_again", 1, ignore_numeric_error_oe_o);
		chk("strap_again", strap, slot_bit1);
		// Non-turbo pacing pulls the strobe low once in every pacing ratio of cycles.
		turbo_off_i = 1;
		cnt = 0;
		repeat (16) begin
			tick(1);
			cnt += int'(!ext_address_strobe_n_o);
		end
		turbo_off_i = 0;
		chk("turbo_mod", 8'(16 / turbo_div_i), 8'(cnt));
		wrap_up();
	end
endmodule : test_cpu_local_bus_control
